// *** hw/odwt_device.sv ***
`timescale 1ns/1ps
module odwt_device #(
    parameter int TICK_CYC = odwt_pkg::TICK_CYC
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    odwt_if.dev LINK,
    input wire logic [2:0] OUTPUT_SWITCH_DELAY_CODE_I,
    input wire logic [1:0] WATCHDOG_PERIOD_CODE_I,
    input wire logic [1:0] OC_BLANK_CODE_I,
    input wire logic [1:0] ON_REQ_I,
    input wire logic [1:0] OC_SEVERE_I,
    input wire logic [1:0] OC_LOW_I,
    input wire logic FAILSAFE_FLOAT_I,
    input wire logic [7:0] TX_BYTE_I,
    output logic [7:0] FRAME_O,
    output logic FRAME_VALID_O,
    output logic [1:0] HIGH_SIDE_OUTPUT_O,
    output logic [1:0] SEVERE_FAULT_O,
    output logic [1:0] LOW_OC_FAULT_O,
    output logic WD_TIMEOUT_O
);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
    logic [9:0] raw;
    logic [9:0] s1_q;
    logic [9:0] s2_q;
    logic [9:0] p_q;
    logic cs_fall;
    logic sclk_rise;
    logic pin_rst;
    logic tick;
    logic [15:0] tick_q, tick_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] rx_q, rx_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] frame_q, frame_d;
    logic fv_q, fv_d;
    odwt_pkg::odwt_wd_t wd_q, wd_d;
    logic [15:0] wcnt_q, wcnt_d;
    logic [15:0] wd_lim;
    logic force_on;
    logic [1:0][15:0] dly_lim;

    assign raw = {FAILSAFE_FLOAT_I, OC_LOW_I, OC_SEVERE_I, LINK.wake,
        LINK.rst_n, LINK.si, LINK.sclk, LINK.cs_n};

    // first stage feeds only the second; edges come from later stages
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            s1_q <= odwt_pkg::SYNC_RST;
            s2_q <= odwt_pkg::SYNC_RST;
            p_q <= odwt_pkg::SYNC_RST;
        end else if (CE_I) begin
            s1_q <= raw;
            s2_q <= s1_q;
            p_q <= s2_q;
        end
    end

    assign cs_fall = p_q[0] && !s2_q[0];
    assign sclk_rise = !p_q[1] && s2_q[1] && !s2_q[0];
    assign pin_rst = !s2_q[3];
    assign tick = tick_q == TICK_LAST;

    // single tick feeds every delay, low blanking and watchdog count; high blanking counts clock cycles
    always_comb begin
        tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            tick_q <= 16'h0000;
        end else if (CE_I) begin
            tick_q <= tick_d;
        end
    end

    always_comb begin
        bit_d = bit_q;
        rx_d = rx_q;
        tx_d = tx_q;
        frame_d = frame_q;
        fv_d = 1'b0;
        if (pin_rst) begin
            bit_d = 3'h0;
            tx_d = 8'h00;
        end else if (cs_fall) begin
            bit_d = 3'h0;
            tx_d = TX_BYTE_I;
        end else if (sclk_rise) begin
            rx_d = {rx_q[6:0], s2_q[2]};
            tx_d = {tx_q[6:0], 1'b0};
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'(odwt_pkg::FRAME_BITS - 1)) begin
                frame_d = {rx_q[6:0], s2_q[2]};
                fv_d = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            bit_q <= 3'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            frame_q <= 8'h00;
            fv_q <= 1'b0;
        end else if (CE_I) begin
            bit_q <= bit_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            frame_q <= frame_d;
            fv_q <= fv_d;
        end
    end

    // two cycles of sync latency, well inside the enable window
    assign LINK.so = tx_q[7];
    assign LINK.so_oe = !s2_q[0];
    assign FRAME_O = frame_q;
    assign FRAME_VALID_O = fv_q;

    assign wd_lim = odwt_pkg::WD_TICKS[WATCHDOG_PERIOD_CODE_I];

    always_comb begin
        wd_d = wd_q;
        wcnt_d = wcnt_q;
        if (pin_rst || !s2_q[4]) begin
            wd_d = odwt_pkg::WD_SLEEP;
            wcnt_d = 16'h0000;
        end else begin
            case (wd_q)
                odwt_pkg::WD_SLEEP: begin
                    // sleep is left only once reset and wake are both high
                    wd_d = odwt_pkg::WD_RUN;
                    wcnt_d = 16'h0000;
                end
                odwt_pkg::WD_RUN: begin
                    if (fv_q) begin
                        wcnt_d = 16'h0000;
                    end else if (tick) begin
                        wcnt_d = wcnt_q + 16'h0001;
                        if (wcnt_d >= wd_lim) begin
                            wd_d = odwt_pkg::WD_EXPIRED;
                        end
                    end
                end
                odwt_pkg::WD_EXPIRED: begin
                    wd_d = odwt_pkg::WD_EXPIRED;
                end
                default: begin
                    wd_d = odwt_pkg::WD_SLEEP;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            wd_q <= odwt_pkg::WD_SLEEP;
            wcnt_q <= 16'h0000;
        end else if (CE_I) begin
            wd_q <= wd_d;
            wcnt_q <= wcnt_d;
        end
    end

    assign WD_TIMEOUT_O = wd_q == odwt_pkg::WD_EXPIRED;
    assign force_on = WD_TIMEOUT_O && s2_q[9];

    assign dly_lim[0] = 16'(OUTPUT_SWITCH_DELAY_CODE_I[2:1]
        * odwt_pkg::DLY_FIRST_STEP);
    assign dly_lim[1] = 16'(OUTPUT_SWITCH_DELAY_CODE_I
        * odwt_pkg::DLY_SECOND_STEP);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            logic [15:0] dcnt_q, dcnt_d;
            logic on_q, on_d;
            logic [15:0] och_q, och_d;
            logic [15:0] ocl_q, ocl_d;
            logic sev_q, sev_d;
            logic low_q, low_d;
            logic hs_q, hs_d;
            logic [15:0] ocl_lim;

            assign ocl_lim = odwt_pkg::OCL_TICKS[OC_BLANK_CODE_I];

            always_comb begin
                dcnt_d = dcnt_q;
                on_d = on_q;
                och_d = och_q;
                ocl_d = ocl_q;
                sev_d = sev_q;
                low_d = low_q;
                if (pin_rst || !ON_REQ_I[ch]) begin
                    dcnt_d = 16'h0000;
                    on_d = 1'b0;
                    sev_d = 1'b0;
                    low_d = 1'b0;
                end else if (!on_q) begin
                    if (dcnt_q >= dly_lim[ch]) begin
                        on_d = 1'b1;
                    end else if (tick) begin
                        dcnt_d = dcnt_q + 16'h0001;
                    end
                end
                if (!hs_q) begin
                    och_d = 16'h0000;
                    ocl_d = 16'h0000;
                end else begin
                    // severe level is the only trip inside high blanking
                    if (s2_q[5 + ch]) begin
                        sev_d = 1'b1;
                    end
                    if (och_q < odwt_pkg::OCH_CYC) begin
                        och_d = och_q + 16'h0001;
                    end else if (!s2_q[7 + ch]) begin
                        ocl_d = 16'h0000;
                    end else if (ocl_q >= ocl_lim) begin
                        low_d = 1'b1;
                    end else if (tick) begin
                        ocl_d = ocl_q + 16'h0001;
                    end
                end
                hs_d = !pin_rst && !sev_d && !low_d
                    && (on_d || force_on);
            end

            always_ff @(posedge CLK_I) begin
                if (!NRST_I) begin
                    dcnt_q <= 16'h0000;
                    on_q <= 1'b0;
                    och_q <= 16'h0000;
                    ocl_q <= 16'h0000;
                    sev_q <= 1'b0;
                    low_q <= 1'b0;
                    hs_q <= 1'b0;
                end else if (CE_I) begin
                    dcnt_q <= dcnt_d;
                    on_q <= on_d;
                    och_q <= och_d;
                    ocl_q <= ocl_d;
                    sev_q <= sev_d;
                    low_q <= low_d;
                    hs_q <= hs_d;
                end
            end

            assign HIGH_SIDE_OUTPUT_O[ch] = hs_q;
            assign SEVERE_FAULT_O[ch] = sev_q;
            assign LOW_OC_FAULT_O[ch] = low_q;
        end
    endgenerate
endmodule

// *** pkg/odwt_pkg.sv ***
// Contract
// - second output delay: 75 ms steps, code
// - first output delay: 150 ms steps, paired
// - watchdog period code picks 620/310/2500/1250 ms
// - watchdog expiry forces outputs on if floating
// - severe level allowed during high blanking
// - low level checked over chosen blanking
// - host holds reset low 350 ns minimum
// - host waits 5 us after reset rise
// - chip select high 300 ns between frames
// - serial clock at most 3 MHz
// - serial output driven/released within 145 ns
// - reset rising edge starts the watchdog
// - watchdog enabled only while wake high
// - 8-bit frames msb first, rising sample
package odwt_pkg;
    localparam int CLK_MHZ = 125;
    localparam int CLK_KHZ = 125000;
    // one shared time base keeps every delay, watchdog and low blanking period equally accurate
    localparam int TICK_US = 50;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int DLY_SECOND_STEP_MS = 75;
    localparam int DLY_FIRST_STEP_MS = 150;
    localparam logic [15:0] DLY_SECOND_STEP =
        16'(DLY_SECOND_STEP_MS * 1000 / TICK_US);
    localparam logic [15:0] DLY_FIRST_STEP =
        16'(DLY_FIRST_STEP_MS * 1000 / TICK_US);
    localparam int WD_MS_0 = 620;
    localparam int WD_MS_1 = 310;
    localparam int WD_MS_2 = 2500;
    localparam int WD_MS_3 = 1250;
    localparam logic [3:0][15:0] WD_TICKS = {
        16'(WD_MS_3 * 1000 / TICK_US), 16'(WD_MS_2 * 1000 / TICK_US),
        16'(WD_MS_1 * 1000 / TICK_US), 16'(WD_MS_0 * 1000 / TICK_US)};
    localparam int OCL_US_0 = 155000;
    localparam int OCL_US_1 = 10000;
    localparam int OCL_US_2 = 1200;
    localparam int OCL_US_3 = 150;
    localparam logic [3:0][15:0] OCL_TICKS = {
        16'(OCL_US_3 / TICK_US), 16'(OCL_US_2 / TICK_US),
        16'(OCL_US_1 / TICK_US), 16'(OCL_US_0 / TICK_US)};
    localparam int OCH_US = 10;
    localparam logic [15:0] OCH_CYC = 16'(OCH_US * CLK_MHZ);
    localparam int RST_LOW_NS = 350;
    localparam int ENBL_NS = 5000;
    localparam int CS_GAP_NS = 300;
    localparam int SO_EN_NS = 145;
    localparam int SCLK_MAX_KHZ = 3000;
    localparam logic [9:0] RST_LOW_CYC =
        10'((RST_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] ENBL_CYC = 10'((ENBL_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] CS_GAP_CYC =
        10'((CS_GAP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] SO_EN_CYC = 10'(SO_EN_NS * CLK_MHZ / 1000);
    localparam logic [9:0] SCLK_HALF_CYC =
        10'((CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ));
    localparam int FRAME_BITS = 8;
    // sync order: cs, sclk, si, rst, wake, severe[2], low[2], fail-safe
    localparam logic [9:0] SYNC_RST = 10'h001;
    typedef enum logic [1:0] {
        WD_SLEEP = 2'b00,
        WD_RUN = 2'b01,
        WD_EXPIRED = 2'b10
    } odwt_wd_t;
    typedef enum logic [2:0] {
        H_RST = 3'b000,
        H_ENBL = 3'b001,
        H_IDLE = 3'b010,
        H_LOW = 3'b011,
        H_HIGH = 3'b100,
        H_GAP = 3'b101
    } odwt_host_t;
endpackage

// *** pkg/odwt_if.sv ***
`timescale 1ns/1ps
interface odwt_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    logic rst_n;
    logic wake;
    modport dev (
        input cs_n,
        input sclk,
        input si,
        input rst_n,
        input wake,
        output so,
        output so_oe
    );
    modport host (
        output cs_n,
        output sclk,
        output si,
        output rst_n,
        output wake,
        input so,
        input so_oe
    );
endinterface

// *** hw/odwt_host.sv ***
`timescale 1ns/1ps
module odwt_host (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    odwt_if.host LINK,
    input wire logic RESET_REQ_I,
    input wire logic WAKE_I,
    input wire logic START_I,
    input wire logic [7:0] TX_BYTE_I,
    output logic READY_O,
    output logic [7:0] RX_BYTE_O,
    output logic DONE_O
);
    odwt_pkg::odwt_host_t st_q, st_d;
    logic [9:0] cnt_q, cnt_d;
    logic [3:0] nb_q, nb_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] rx_q, rx_d;
    logic done_q, done_d;
    logic cs_q, cs_d;
    logic sclk_q, sclk_d;
    logic rst_q, rst_d;
    logic wake_q;
    logic so1_q;
    logic so2_q;
    logic half;

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            so1_q <= 1'b0;
            so2_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (CE_I) begin
            so1_q <= LINK.so;
            so2_q <= so1_q;
            wake_q <= WAKE_I;
        end
    end

    // clock halves are rounded up so the rate never passes the limit
    assign half = cnt_q == odwt_pkg::SCLK_HALF_CYC - 10'h001;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 10'h001;
        nb_d = nb_q;
        sh_d = sh_q;
        rx_d = rx_q;
        done_d = 1'b0;
        cs_d = cs_q;
        sclk_d = sclk_q;
        rst_d = rst_q;
        case (st_q)
            odwt_pkg::H_RST: begin
                rst_d = 1'b0;
                cs_d = 1'b1;
                sclk_d = 1'b0;
                if (cnt_q == odwt_pkg::RST_LOW_CYC - 10'h001) begin
                    st_d = odwt_pkg::H_ENBL;
                    cnt_d = 10'h000;
                    rst_d = 1'b1;
                end
            end
            odwt_pkg::H_ENBL: begin
                if (cnt_q == odwt_pkg::ENBL_CYC - 10'h001) begin
                    st_d = odwt_pkg::H_IDLE;
                end
            end
            odwt_pkg::H_IDLE: begin
                cnt_d = 10'h000;
                if (RESET_REQ_I) begin
                    // pin drops with the state change so the low time is full
                    st_d = odwt_pkg::H_RST;
                    rst_d = 1'b0;
                end else if (START_I) begin
                    st_d = odwt_pkg::H_LOW;
                    cs_d = 1'b0;
                    sh_d = TX_BYTE_I;
                    nb_d = 4'h0;
                end
            end
            odwt_pkg::H_LOW: begin
                if (half) begin
                    cnt_d = 10'h000;
                    if (nb_q == 4'(odwt_pkg::FRAME_BITS)) begin
                        st_d = odwt_pkg::H_GAP;
                        cs_d = 1'b1;
                        done_d = 1'b1;
                    end else begin
                        st_d = odwt_pkg::H_HIGH;
                        sclk_d = 1'b1;
                        rx_d = {rx_q[6:0], so2_q};
                    end
                end
            end
            odwt_pkg::H_HIGH: begin
                if (half) begin
                    // next bit appears with the falling clock edge
                    st_d = odwt_pkg::H_LOW;
                    cnt_d = 10'h000;
                    sclk_d = 1'b0;
                    sh_d = {sh_q[6:0], 1'b0};
                    nb_d = nb_q + 4'h1;
                end
            end
            odwt_pkg::H_GAP: begin
                if (cnt_q == odwt_pkg::CS_GAP_CYC - 10'h001) begin
                    st_d = odwt_pkg::H_IDLE;
                end
            end
            default: begin
                st_d = odwt_pkg::H_RST;
                cnt_d = 10'h000;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            st_q <= odwt_pkg::H_RST;
            cnt_q <= 10'h000;
            nb_q <= 4'h0;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            done_q <= 1'b0;
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
            rst_q <= 1'b0;
        end else if (CE_I) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            nb_q <= nb_d;
            sh_q <= sh_d;
            rx_q <= rx_d;
            done_q <= done_d;
            cs_q <= cs_d;
            sclk_q <= sclk_d;
            rst_q <= rst_d;
        end
    end

    assign LINK.cs_n = cs_q;
    assign LINK.sclk = sclk_q;
    assign LINK.si = sh_q[7];
    assign LINK.rst_n = rst_q;
    assign LINK.wake = wake_q;
    assign READY_O = st_q == odwt_pkg::H_IDLE && !RESET_REQ_I;
    assign RX_BYTE_O = rx_q;
    assign DONE_O = done_q;
endmodule

// *** testbench/odwt_chk.sv ***
`timescale 1ns/1ps
module odwt_chk (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic rst_n,
    input wire logic wake
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);
    // saturating counters so long idle stretches never wrap
    logic [9:0] low_q, en_q, gap_q, half_q;
    logic [3:0] bits_q;
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            low_q <= 10'h000;
            en_q <= 10'h000;
            gap_q <= 10'h000;
            half_q <= 10'h000;
            bits_q <= 4'h0;
        end else begin
            low_q <= rst_n ? 10'h000 : low_q + 10'(low_q != 10'h3ff);
            en_q <= !rst_n ? 10'h000 : en_q + 10'(en_q != 10'h3ff);
            gap_q <= !cs_n ? 10'h000 : gap_q + 10'(gap_q != 10'h3ff);
            half_q <= $changed(sclk) ? 10'h001
                : half_q + 10'(half_q != 10'h3ff);
            bits_q <= cs_n ? 4'h0 : bits_q + 4'($rose(sclk));
        end
    end
    chk_rst_low_len: assert property (
        $rose(rst_n) |-> low_q >= odwt_pkg::RST_LOW_CYC)
        else $error("reset pulse too short");
    chk_enbl_wait: assert property (
        $fell(cs_n) |-> en_q >= odwt_pkg::ENBL_CYC)
        else $error("frame too soon after reset");
    chk_cs_gap: assert property (
        $fell(cs_n) |-> gap_q >= odwt_pkg::CS_GAP_CYC)
        else $error("chip select gap too short");
    chk_sclk_half: assert property (
        $changed(sclk) |-> half_q >= odwt_pkg::SCLK_HALF_CYC)
        else $error("serial clock too fast");
    chk_so_drive: assert property (
        $fell(cs_n) |-> ##[1:18] so_oe)
        else $error("serial output not driven in time");
    chk_so_release: assert property (
        $rose(cs_n) |-> ##[1:18] !so_oe)
        else $error("serial output not released in time");
    chk_si_hold: assert property (
        sclk && $past(sclk) |-> $stable(si))
        else $error("serial input moved while clock high");
    chk_sclk_idle: assert property (
        cs_n |-> !sclk)
        else $error("serial clock high outside frame");
    chk_frame_bits: assert property (
        $rose(cs_n) |-> bits_q == 4'h8)
        else $error("frame not eight bits");
endmodule

// *** testbench/test_output_delay_watchdog_timer.sv ***
`timescale 1ns/1ps
module test_output_delay_watchdog_timer;
    localparam int TICK = 1;
    localparam int LIMIT = 60000;
    logic clk = 1'h0, nrst = 1'h0;
    logic rst_req = 1'h0, wake = 1'h0, start = 1'h0, fs = 1'h0;
    logic [7:0] htx = 8'h00, dtx = 8'h00, hb, db, si_sh, so_sh, rx, frm;
    logic [2:0] dly_code = 3'h0;
    logic [1:0] wd_code = 2'h0, blank = 2'h3, on_req = 2'h0;
    logic [1:0] oc_sev = 2'h0, oc_low = 2'h0, hs, sev_f, low_f, hs_q;
    logic ready, done, fvld, wdto, wd_q;
    logic [3:0] flt_q = 4'h0;
    logic [31:0] q0[$], q1[$], q_wd[$], q_flt[$], q_frm[$], q_rx[$];
    int cyc = 0, t_on = 0, t_wd = 0, fail_count = 0, compares = 0;
    integer seed = 32'h77a0_4e52;
    odwt_if lnk ();
    odwt_host u_odwt_host (.CLK_I(clk), .NRST_I(nrst), .CE_I(1'h1),
        .LINK(lnk.host), .RESET_REQ_I(rst_req), .WAKE_I(wake),
        .START_I(start), .TX_BYTE_I(htx), .READY_O(ready),
        .RX_BYTE_O(rx), .DONE_O(done));
    odwt_device #(.TICK_CYC(TICK)) u_odwt_device (.CLK_I(clk),
        .NRST_I(nrst), .CE_I(1'h1), .LINK(lnk.dev),
        .OUTPUT_SWITCH_DELAY_CODE_I(dly_code),
        .WATCHDOG_PERIOD_CODE_I(wd_code), .OC_BLANK_CODE_I(blank),
        .ON_REQ_I(on_req), .OC_SEVERE_I(oc_sev), .OC_LOW_I(oc_low),
        .FAILSAFE_FLOAT_I(fs), .TX_BYTE_I(dtx), .FRAME_O(frm),
        .FRAME_VALID_O(fvld), .HIGH_SIDE_OUTPUT_O(hs),
        .SEVERE_FAULT_O(sev_f), .LOW_OC_FAULT_O(low_f),
        .WD_TIMEOUT_O(wdto));
    odwt_chk u_odwt_chk (.CLK_I(clk), .NRST_I(nrst), .cs_n(lnk.cs_n),
        .sclk(lnk.sclk), .si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe),
        .rst_n(lnk.rst_n), .wake(lnk.wake));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic stop_test();
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input bit ok, input string m);
        compares++;
        if (!ok) begin
            fail_count++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask
    function automatic logic [31:0] pop(ref logic [31:0] q[$]);
        if (q.size() == 0)
            return 'x;
        return q.pop_front();
    endfunction
    // tick phase and input syncs blur the edge by a few cycles
    function automatic bit near(input int a, input logic [31:0] e);
        return !$isunknown(e) && a >= int'(e) - 6 && a <= int'(e) + 6;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic frame(input logic [7:0] h, input logic [7:0] d);
        while (ready !== 1'h1) @(posedge clk);
        htx <= h;
        dtx <= d;
        start <= 1'h1;
        hb = h;
        db = d;
        q_frm.push_back(32'(h));
        q_rx.push_back(32'(d));
        @(posedge clk);
        start <= 1'h0;
        do @(posedge clk); while (done !== 1'h1);
    endtask
    task automatic req(input logic [1:0] m, input int c);
        int f;
        int s;
        f = int'(odwt_pkg::DLY_FIRST_STEP) * (c / 2) * TICK + 4;
        s = int'(odwt_pkg::DLY_SECOND_STEP) * c * TICK + 4;
        @(posedge clk);
        dly_code <= 3'(c);
        on_req <= m;
        t_on = cyc;
        if (m[0]) q0.push_back(f);
        if (m[1]) q1.push_back(s);
        while ((hs & m) !== m) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail_count++;
            stop_test();
        end
    end
    always @(posedge lnk.rst_n) t_wd = cyc;
    always @(posedge lnk.sclk) begin
        si_sh = {si_sh[6:0], lnk.si};
        so_sh = {so_sh[6:0], lnk.so};
        check(lnk.so_oe === 1'h1, "so not driven");
    end
    always @(posedge lnk.cs_n) begin
        if (nrst === 1'h1) begin
            check(si_sh === hb, "si order");
            check(so_sh === db, "so order");
        end
    end
    always @(negedge clk) begin
        if (fvld === 1'h1)
            check(32'(frm) === pop(q_frm), "frame");
        if (done === 1'h1)
            check(32'(rx) === pop(q_rx), "rx byte");
        if (hs[0] === 1'h1 && hs_q[0] !== 1'h1 && wdto !== 1'h1)
            check(near(cyc - t_on, pop(q0)), "delay 0");
        if (hs[1] === 1'h1 && hs_q[1] !== 1'h1 && wdto !== 1'h1)
            check(near(cyc - t_on, pop(q1)), "delay 1");
        if (wdto === 1'h1 && wd_q !== 1'h1)
            check(near(cyc - t_wd, pop(q_wd)), "wd");
        if ({sev_f, low_f} !== flt_q && |{sev_f, low_f} === 1'h1)
            check(32'({sev_f, low_f}) === pop(q_flt), "fault");
        hs_q = hs;
        wd_q = wdto;
        flt_q = {sev_f, low_f};
    end
    initial begin
        tick(4);
        nrst <= 1'h1;
        frame(8'h80, 8'h01);
        for (int i = 0; i < 3; i++)
            frame(8'($random(seed)), 8'($random(seed)));
        // wake low here, so any timeout is a mismatch
        for (int c = 0; c < 8; c++) begin
            req(2'h3, c);
            on_req <= 2'h0;
            tick(3);
        end
        req(2'h2, 0);
        oc_sev <= 2'h2;
        q_flt.push_back(32'h0000_0008);
        tick(10);
        check(hs[1] === 1'h0 && q_flt.size() == 0, "severe");
        on_req <= 2'h0;
        oc_sev <= 2'h0;
        tick(4);
        req(2'h1, 0);
        oc_low <= 2'h1;
        q_flt.push_back(32'h0000_0001);
        tick(1200);
        check(low_f === 2'h0, "early low trip");
        tick(100);
        check(hs[0] === 1'h0 && q_flt.size() == 0, "low trip");
        on_req <= 2'h0;
        oc_low <= 2'h0;
        wd_code <= 2'h1;
        fs <= 1'h1;
        wake <= 1'h1;
        rst_req <= 1'h1;
        tick(2);
        rst_req <= 1'h0;
        q_wd.push_back(int'(odwt_pkg::WD_TICKS[1]) * TICK + 3);
        while (wdto !== 1'h1) @(posedge clk);
        tick(4);
        check(hs === 2'h3, "failsafe on");
        wake <= 1'h0;
        tick(8);
        check(wdto === 1'h0, "wd off");
        stop_test();
    end
endmodule
